// File: core/host_port_regs.svh
// timing constants for the host port and discrete i/o strobes
`ifndef HOST_PORT_REGS_SVH
`define HOST_PORT_REGS_SVH

`define CLK_FREQ_MHZ 25
`define CLK_PERIOD_NS (1000 / `CLK_FREQ_MHZ)
// least times round up, longest times round down
`define CYC_UP(ns) (((ns) + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define CYC_DN(ns) ((ns) / `CLK_PERIOD_NS)

`define SYNC_LAT_CYC 2

`define IO_RD_MIN_NS 190
`define IO_RD_MAX_NS 210
`define IO_WR_MIN_NS 90
`define IO_WR_MAX_NS 110
`define CMD_MIN_NS 290
`define CMD_MAX_NS 310
`define IO_ADDR_SETUP_NS 50
`define IO_ADDR_HOLD_NS 50
`define CMD_WR_LEAD_NS 40
`define CMD_WR_TAIL_NS 100
`define CMD_RD_LEAD_NS 100
`define CMD_RD_TAIL_NS 100
`define VEC_ACK_MIN_NS 300
`define VEC_ACK_MAX_NS 400

`define IO_RD_CYC `CYC_UP(`IO_RD_MIN_NS)
`define IO_WR_CYC `CYC_UP(`IO_WR_MIN_NS)
`define CMD_CYC `CYC_UP(`CMD_MIN_NS)
`define IO_SETUP_CYC `CYC_UP(`IO_ADDR_SETUP_NS)
`define IO_HOLD_CYC `CYC_UP(`IO_ADDR_HOLD_NS)
`define CMD_WR_LEAD_CYC `CYC_UP(`CMD_WR_LEAD_NS)
`define CMD_WR_TAIL_CYC `CYC_UP(`CMD_WR_TAIL_NS)
`define CMD_RD_LEAD_CYC `CYC_UP(`CMD_RD_LEAD_NS)
`define CMD_RD_TAIL_CYC `CYC_UP(`CMD_RD_TAIL_NS)
// the input synchroniser already eats part of the delay
`define VEC_ACK_CYC (`CYC_UP(`VEC_ACK_MIN_NS) - `SYNC_LAT_CYC)

`endif

// File: core/host_port_pkg.sv
// types for the host port and discrete i/o strobe block
`default_nettype none
package host_port_pkg;

  typedef enum logic [1:0] {
    H_IDLE,
    H_MEM,
    H_VEC,
    H_ACK_END
  } host_state_t;

  typedef enum logic [1:0] {
    IO_IDLE,
    IO_SETUP,
    IO_STROBE,
    IO_HOLD
  } io_state_t;

  typedef struct packed {
    logic write;
    logic [1:0] byte_en;
    logic [13:0] addr;
    logic [15:0] wdata;
  } mem_req_t;

  typedef struct packed {
    logic write;
    logic cmd;
    logic [1:0] addr;
    logic [7:0] wdata;
  } io_req_t;

endpackage : host_port_pkg
`default_nettype wire

// File: core/host_io_port.sv
// host memory port, interrupt acknowledge chain and discrete i/o strobes
`timescale 1ns/100ps
`default_nettype none
`include "host_port_regs.svh"

module host_io_port (
  // clock and reset
  input wire logic clk_sys,
  input wire logic reset_n,
  // host bus pins
  input wire logic host_select_n,
  input wire logic host_read_n,
  input wire logic host_write_low_byte_n,
  input wire logic host_write_high_byte_n,
  input wire logic [14:1] host_addr,
  input wire logic [15:0] host_data_in,
  output logic [15:0] host_data_out,
  output logic host_data_oe,
  output logic transfer_ack_n_out,
  output logic transfer_ack_n_oe,
  // interrupt pins
  input wire logic interrupt_ack_n,
  input wire logic priority_chain_in_n,
  output logic priority_out_or_disconnect,
  output logic irq_n_out,
  output logic irq_n_oe,
  // discrete i/o pins
  output logic io_read_n,
  output logic io_write_n,
  output logic [2:1] io_addr,
  output logic command_strobe,
  input wire logic [7:0] discrete_data_in,
  output logic [7:0] discrete_data_out,
  output logic discrete_data_oe,
  // mode inputs from the terminal core
  input wire logic rt_mode,
  input wire logic chain_select_disconnect,
  input wire logic store_disconnected,
  // internal memory port
  output logic mem_req_valid,
  output host_port_pkg::mem_req_t mem_req,
  input wire logic mem_ack,
  input wire logic [15:0] mem_rdata,
  // vector fifo port
  input wire logic fifo_not_empty,
  input wire logic [7:0] fifo_vector,
  output logic fifo_pop,
  // discrete i/o request port
  input wire logic io_req_valid,
  input wire host_port_pkg::io_req_t io_req,
  output logic io_req_ready,
  output logic io_done,
  output logic [7:0] io_rdata
);

  localparam int SW = 44;

  function automatic int max2(input int a, input int b);
    max2 = (a > b) ? a : b;
  endfunction : max2

  function automatic logic [3:0] lead_cyc(input host_port_pkg::io_req_t r);
    int n;
    n = `IO_SETUP_CYC;
    if (r.cmd && r.write) begin
      n = max2(n, max2(`CMD_WR_LEAD_CYC, `CMD_CYC - `IO_WR_CYC - `CMD_WR_TAIL_CYC));
    end else if (r.cmd) begin
      n = max2(n, `CMD_RD_LEAD_CYC);
    end
    lead_cyc = 4'(n - 1);
  endfunction : lead_cyc

  function automatic logic [3:0] tail_cyc(input host_port_pkg::io_req_t r);
    int n;
    n = `IO_HOLD_CYC;
    if (r.cmd) begin
      n = max2(n, r.write ? `CMD_WR_TAIL_CYC : `CMD_RD_TAIL_CYC);
    end
    tail_cyc = 4'(n - 1);
  endfunction : tail_cyc

  // two-stage synchroniser on every pin input
  logic [SW-1:0] pins;
  logic [SW-1:0] sync1_reg;
  logic [SW-1:0] sync2_reg;
  assign pins = {host_select_n, host_read_n, host_write_low_byte_n,
                 host_write_high_byte_n, interrupt_ack_n, priority_chain_in_n,
                 host_addr, host_data_in, discrete_data_in};

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      sync1_reg <= {SW{1'b1}};
      sync2_reg <= {SW{1'b1}};
    end else begin
      sync1_reg <= pins;
      sync2_reg <= sync1_reg;
    end
  end

  logic sel_n_s, rd_n_s, wrl_n_s, wrh_n_s, inta_n_s, pin_n_s;
  logic [13:0] addr_s;
  logic [15:0] hdata_s;
  logic [7:0] ddata_s;
  assign {sel_n_s, rd_n_s, wrl_n_s, wrh_n_s, inta_n_s, pin_n_s,
          addr_s, hdata_s, ddata_s} = sync2_reg;

  // ---------------- discrete i/o sequencer ----------------
  host_port_pkg::io_state_t io_state_reg, io_state_next;
  logic [3:0] io_cnt_reg, io_cnt_next;
  host_port_pkg::io_req_t io_cur_reg, io_cur_next;
  logic [7:0] io_rdata_reg, io_rdata_next;
  logic io_done_reg, io_done_next;
  logic io_rd_n_reg, io_rd_n_next;
  logic io_wr_n_reg, io_wr_n_next;
  logic cmd_reg, cmd_next;
  logic ddata_oe_reg, ddata_oe_next;

  always_comb begin
    io_state_next = io_state_reg;
    io_cnt_next = io_cnt_reg;
    io_cur_next = io_cur_reg;
    io_rdata_next = io_rdata_reg;
    io_done_next = 1'b0;
    case (io_state_reg)
      host_port_pkg::IO_IDLE: begin
        if (io_req_valid) begin
          io_cur_next = io_req;
          io_cnt_next = lead_cyc(io_req);
          io_state_next = host_port_pkg::IO_SETUP;
        end
      end
      host_port_pkg::IO_SETUP: begin
        if (io_cnt_reg == 4'h0) begin
          io_cnt_next = io_cur_reg.write ? 4'(`IO_WR_CYC - 1) : 4'(`IO_RD_CYC - 1);
          io_state_next = host_port_pkg::IO_STROBE;
        end else begin
          io_cnt_next = io_cnt_reg - 4'h1;
        end
      end
      host_port_pkg::IO_STROBE: begin
        if (io_cnt_reg == 4'h0) begin
          if (!io_cur_reg.write) begin
            io_rdata_next = ddata_s;
          end
          io_cnt_next = tail_cyc(io_cur_reg);
          io_state_next = host_port_pkg::IO_HOLD;
        end else begin
          io_cnt_next = io_cnt_reg - 4'h1;
        end
      end
      host_port_pkg::IO_HOLD: begin
        if (io_cnt_reg == 4'h0) begin
          io_done_next = 1'b1;
          io_state_next = host_port_pkg::IO_IDLE;
        end else begin
          io_cnt_next = io_cnt_reg - 4'h1;
        end
      end
      default: begin
        io_state_next = host_port_pkg::IO_IDLE;
      end
    endcase
    io_rd_n_next = !(io_state_next == host_port_pkg::IO_STROBE && !io_cur_next.write);
    io_wr_n_next = !(io_state_next == host_port_pkg::IO_STROBE && io_cur_next.write);
    // command strobe over the whole sequence
    cmd_next = io_cur_next.cmd && io_state_next != host_port_pkg::IO_IDLE;
    ddata_oe_next = io_cur_next.write && io_state_next != host_port_pkg::IO_IDLE;
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      io_state_reg <= host_port_pkg::IO_IDLE;
      io_cnt_reg <= 4'h0;
      io_cur_reg <= '0;
      io_rdata_reg <= 8'h00;
      io_done_reg <= 1'b0;
      io_rd_n_reg <= 1'b1;
      io_wr_n_reg <= 1'b1;
      cmd_reg <= 1'b0;
      ddata_oe_reg <= 1'b0;
    end else begin
      io_state_reg <= io_state_next;
      io_cnt_reg <= io_cnt_next;
      io_cur_reg <= io_cur_next;
      io_rdata_reg <= io_rdata_next;
      io_done_reg <= io_done_next;
      io_rd_n_reg <= io_rd_n_next;
      io_wr_n_reg <= io_wr_n_next;
      cmd_reg <= cmd_next;
      ddata_oe_reg <= ddata_oe_next;
    end
  end

  // ---------------- host cycle sequencer ----------------
  host_port_pkg::host_state_t h_state_reg, h_state_next;
  logic [3:0] h_cnt_reg, h_cnt_next;
  logic [4:0] prev_reg, prev_next;
  logic [13:0] addr_lat_reg, addr_lat_next;
  logic rd_cyc_reg, rd_cyc_next;
  logic [15:0] hdout_reg, hdout_next;
  logic ack_oe_reg, ack_oe_next;
  logic hd_oe_reg, hd_oe_next;
  logic mreq_v_reg, mreq_v_next;
  host_port_pkg::mem_req_t mreq_reg, mreq_next;
  logic pop_reg, pop_next;
  logic irq_reg, irq_next;
  logic sel_a, rd_a, wr_a, inta_a, sel_fall, acking;
  logic rd_end, wr_end;
  logic [13:0] addr_now;

  always_comb begin
    sel_a = !sel_n_s;
    rd_a = !rd_n_s;
    wr_a = !wrl_n_s || !wrh_n_s;
    inta_a = !inta_n_s;
    sel_fall = prev_reg[4] && sel_n_s == 1'b0;
    addr_now = sel_fall ? addr_s : addr_lat_reg;
    // read end on first rising strobe
    rd_end = !rd_a || !sel_a || (io_rd_n_reg && !prev_reg[1]);
    // write end on first rising strobe
    wr_end = !wr_a || !sel_a || (io_wr_n_reg && !prev_reg[0]);
    h_state_next = h_state_reg;
    h_cnt_next = h_cnt_reg;
    addr_lat_next = addr_now;
    rd_cyc_next = rd_cyc_reg;
    hdout_next = hdout_reg;
    mreq_v_next = mreq_v_reg;
    mreq_next = mreq_reg;
    pop_next = 1'b0;
    acking = 1'b0;
    case (h_state_reg)
      host_port_pkg::H_IDLE: begin
        if (sel_a && (rd_a || wr_a)) begin
          rd_cyc_next = rd_a;
          mreq_v_next = 1'b1;
          mreq_next = '{write: !rd_a, byte_en: {!wrh_n_s, !wrl_n_s},
                        addr: addr_now, wdata: hdata_s};
          h_state_next = host_port_pkg::H_MEM;
        end else if (!sel_a && inta_a && rd_a && rt_mode && !pin_n_s && fifo_not_empty) begin
          rd_cyc_next = 1'b1;
          pop_next = 1'b1;
          hdout_next = {fifo_vector, fifo_vector};
          // acknowledge delay from read and acknowledge
          h_cnt_next = 4'(`VEC_ACK_CYC - 1);
          h_state_next = host_port_pkg::H_VEC;
        end
      end
      host_port_pkg::H_MEM: begin
        // acknowledge waits on the memory answer
        if (mem_ack) begin
          mreq_v_next = 1'b0;
          if (rd_cyc_reg) begin
            hdout_next = mem_rdata;
          end
          h_state_next = host_port_pkg::H_ACK_END;
        end
      end
      host_port_pkg::H_VEC: begin
        if (!rd_a) begin
          h_state_next = host_port_pkg::H_ACK_END;
        end else if (h_cnt_reg == 4'h0) begin
          h_state_next = host_port_pkg::H_ACK_END;
        end else begin
          h_cnt_next = h_cnt_reg - 4'h1;
        end
      end
      host_port_pkg::H_ACK_END: begin
        // ack held until a memory cycle ends, for one clock only in a vector read
        acking = !(rd_cyc_reg ? rd_end : wr_end) && ack_oe_reg;
        if (!rd_a && !wr_a) begin
          h_state_next = host_port_pkg::H_IDLE;
        end
      end
      default: begin
        h_state_next = host_port_pkg::H_IDLE;
      end
    endcase
    // acknowledge released once a memory cycle ends, one clock after it rises in a vector read
    ack_oe_next = (h_state_next == host_port_pkg::H_ACK_END)
                  && (h_state_reg != host_port_pkg::H_ACK_END || acking)
                  && !(h_state_reg == host_port_pkg::H_VEC && !rd_a);
    // data driven only under host read
    hd_oe_next = ack_oe_next && rd_cyc_next && rd_a;
    // request held while fifo has entries and interrupt acknowledge is not active
    irq_next = fifo_not_empty && !inta_a;
    prev_next = {sel_n_s, rd_n_s, wr_a, io_rd_n_reg, io_wr_n_reg};
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      h_state_reg <= host_port_pkg::H_IDLE;
      h_cnt_reg <= 4'h0;
      prev_reg <= 5'h1b;
      addr_lat_reg <= 14'h0000;
      rd_cyc_reg <= 1'b0;
      hdout_reg <= 16'h0000;
      ack_oe_reg <= 1'b0;
      hd_oe_reg <= 1'b0;
      mreq_v_reg <= 1'b0;
      mreq_reg <= '0;
      pop_reg <= 1'b0;
      irq_reg <= 1'b0;
    end else begin
      h_state_reg <= h_state_next;
      h_cnt_reg <= h_cnt_next;
      prev_reg <= prev_next;
      addr_lat_reg <= addr_lat_next;
      rd_cyc_reg <= rd_cyc_next;
      hdout_reg <= hdout_next;
      ack_oe_reg <= ack_oe_next;
      hd_oe_reg <= hd_oe_next;
      mreq_v_reg <= mreq_v_next;
      mreq_reg <= mreq_next;
      pop_reg <= pop_next;
      irq_reg <= irq_next;
    end
  end

  // store_disconnected when chain_select_disconnect is set, else high when requesting, else chain input
  assign priority_out_or_disconnect = chain_select_disconnect ? store_disconnected
                                      : (irq_reg || pin_n_s);

  assign host_data_out = hdout_reg;
  assign host_data_oe = hd_oe_reg;
  assign transfer_ack_n_out = 1'b0;
  assign transfer_ack_n_oe = ack_oe_reg;
  assign irq_n_out = 1'b0;
  assign irq_n_oe = irq_reg;
  assign io_read_n = io_rd_n_reg;
  assign io_write_n = io_wr_n_reg;
  assign io_addr = io_cur_reg.addr;
  assign command_strobe = cmd_reg;
  assign discrete_data_out = io_cur_reg.wdata;
  assign discrete_data_oe = ddata_oe_reg;
  assign mem_req_valid = mreq_v_reg;
  assign mem_req = mreq_reg;
  assign fifo_pop = pop_reg;
  assign io_req_ready = io_state_reg == host_port_pkg::IO_IDLE;
  assign io_done = io_done_reg;
  assign io_rdata = io_rdata_reg;

endmodule : host_io_port

`default_nettype wire

// File: testbench/host_io_port_chk.sv
// concurrent checks on the host port and discrete strobe pins
`timescale 1ns/100ps
`default_nettype none

module host_io_port_chk (
  // clock and reset
  input wire logic clk_sys,
  input wire logic reset_n,
  // host pins
  input wire logic host_select_n,
  input wire logic host_read_n,
  input wire logic host_write_low_byte_n,
  input wire logic host_write_high_byte_n,
  input wire logic [15:0] host_data_out,
  input wire logic transfer_ack_n_oe,
  // interrupt pins and mode inputs
  input wire logic interrupt_ack_n,
  input wire logic priority_out_or_disconnect,
  input wire logic irq_n_oe,
  input wire logic chain_select_disconnect,
  input wire logic rt_mode,
  // discrete pins
  input wire logic io_read_n,
  input wire logic io_write_n,
  input wire logic [2:1] io_addr,
  input wire logic command_strobe
);
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!reset_n);
  logic idle;
  assign idle = host_read_n && host_write_low_byte_n && host_write_high_byte_n;

  AST_RD_WIDTH: assert property ($fell(io_read_n) |-> !io_read_n [*5] ##1 io_read_n)
    else $error("io read strobe width wrong");
  AST_WR_WIDTH: assert property ($fell(io_write_n) |-> !io_write_n [*3] ##1 io_write_n)
    else $error("io write strobe width wrong");
  AST_ADDR_SETUP: assert property (($fell(io_read_n) || $fell(io_write_n))
    |-> io_addr == $past(io_addr) && io_addr == $past(io_addr, 2)) else $error("io address setup short");
  AST_ADDR_HOLD: assert property (($rose(io_read_n) || $rose(io_write_n)) |-> $stable(io_addr) [*2])
    else $error("io address hold short");
  AST_CMD_WIDTH: assert property ($rose(command_strobe) |-> command_strobe [*8])
    else $error("command strobe too short");
  AST_CMD_LEAD_RD: assert property ($fell(io_read_n) && command_strobe |-> $past(command_strobe, 3))
    else $error("command strobe lead short");
  AST_CMD_TAIL: assert property (($rose(io_write_n) || $rose(io_read_n)) && $past(command_strobe)
    |-> command_strobe [*3]) else $error("command strobe tail short");
  AST_ACK_REL: assert property (idle [*4] |-> !transfer_ack_n_oe)
    else $error("transfer ack not released");
  AST_VEC_ACK: assert property ($fell(host_read_n) && !interrupt_ack_n && host_select_n && rt_mode
    |-> !transfer_ack_n_oe [*8] ##1 !transfer_ack_n_oe ##[1:2] transfer_ack_n_oe) else $error("vector ack time");
  AST_VEC_BYTES: assert property (transfer_ack_n_oe && host_select_n && !interrupt_ack_n
    |-> host_data_out[15:8] == host_data_out[7:0]) else $error("vector not on both bytes");
  AST_IRQ_DROP: assert property ($fell(interrupt_ack_n) |-> ##[0:5] !irq_n_oe)
    else $error("request not dropped");
  AST_CHAIN_REQ: assert property (!chain_select_disconnect && irq_n_oe |-> priority_out_or_disconnect)
    else $error("chain output low while requesting");

  cover property ($fell(io_read_n) && command_strobe);
  cover property ($fell(io_write_n) && command_strobe);
  cover property ($rose(transfer_ack_n_oe) && host_select_n);
endmodule : host_io_port_chk

bind host_io_port host_io_port_chk u_chk (.clk_sys, .reset_n, .host_select_n, .host_read_n,
  .host_write_low_byte_n, .host_write_high_byte_n, .host_data_out, .transfer_ack_n_oe, .interrupt_ack_n,
  .priority_out_or_disconnect, .irq_n_oe, .chain_select_disconnect, .rt_mode, .io_read_n, .io_write_n,
  .io_addr, .command_strobe);
`default_nettype wire

// File: testbench/far_side_model.sv
// internal memory and discrete device seen by the host port
`timescale 1ns/100ps
`default_nettype none

module far_side_model (
  // clock and reset
  input wire logic clk_sys,
  input wire logic reset_n,
  // answer delay in cycles
  input wire logic [3:0] lat,
  // memory port
  input wire logic mem_req_valid,
  input wire host_port_pkg::mem_req_t mem_req,
  output logic mem_ack,
  output logic [15:0] mem_rdata,
  // discrete pins
  input wire logic io_read_n,
  input wire logic [2:1] io_addr,
  input wire logic [7:0] discrete_data_out,
  input wire logic discrete_data_oe,
  output logic [7:0] discrete_data_in
);
  logic [15:0] mem [16];
  logic [3:0] cnt;
  // a released bus floats up on the pull-up
  assign discrete_data_in = discrete_data_oe ? discrete_data_out : (!io_read_n ? {6'h28, io_addr} : 8'hff);
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      cnt <= 4'h0;
      mem_ack <= 1'b0;
      mem_rdata <= 16'h0;
      for (int i = 0; i < 16; i++) mem[i] <= 16'h0;
    end else if (mem_req_valid && !mem_ack && cnt < lat) begin
      cnt <= cnt + 4'h1;
      mem_rdata <= ~mem_rdata;
    end else if (mem_req_valid && !mem_ack) begin
      cnt <= 4'h0;
      mem_ack <= 1'b1;
      mem_rdata <= mem[mem_req.addr[3:0]];
      if (mem_req.write && mem_req.byte_en[0]) mem[mem_req.addr[3:0]][7:0] <= mem_req.wdata[7:0];
      if (mem_req.write && mem_req.byte_en[1]) mem[mem_req.addr[3:0]][15:8] <= mem_req.wdata[15:8];
    end else begin
      mem_ack <= 1'b0;
      mem_rdata <= ~mem_rdata;
    end
  end
endmodule : far_side_model
`default_nettype wire

// File: testbench/host_io_port_bench.sv
// self-checking bench for the host port and discrete strobe block
`timescale 1ns/100ps
`default_nettype none

module host_io_port_bench;
  typedef struct packed {
    logic wr;
    logic [1:0] be;
    logic [3:0] a;
    logic [15:0] d;
    logic [3:0] lat;
  } row_t;
  logic clk_sys, reset_n, host_select_n, host_read_n, host_write_low_byte_n, host_write_high_byte_n;
  logic [14:1] host_addr;
  logic [15:0] host_data_in, host_data_out, hd, q, mem_rdata;
  logic host_data_oe, transfer_ack_n_out, transfer_ack_n_oe, interrupt_ack_n, priority_chain_in_n;
  logic priority_out_or_disconnect, irq_n_out, irq_n_oe, io_read_n, io_write_n, command_strobe;
  logic [2:1] io_addr;
  logic [7:0] discrete_data_in, discrete_data_out, io_rdata, fifo_vector, wd;
  logic discrete_data_oe, rt_mode, chain_select_disconnect, store_disconnected, mem_req_valid, mem_ack;
  logic fifo_not_empty, fifo_pop, io_req_valid, io_req_ready, io_done;
  logic [3:0] lat;
  host_port_pkg::mem_req_t mem_req;
  host_port_pkg::io_req_t io_req;
  int failures, n_compared, cyc, n, nlow, ncmd, npop;
  int lw[4] = '{3, 3, 5, 5};
  int cw[4] = '{0, 8, 0, 10};
  row_t rows[6] = '{'{1'b1, 2'h3, 4'h1, 16'h1234, 4'h0}, '{1'b1, 2'h1, 4'h1, 16'habcd, 4'h2},
    '{1'b1, 2'h2, 4'h2, 16'hff00, 4'h0}, '{1'b0, 2'h0, 4'h1, 16'h12cd, 4'h0},
    '{1'b0, 2'h0, 4'h2, 16'hff00, 4'h9}, '{1'b0, 2'h0, 4'h3, 16'h0000, 4'h1}};

  host_io_port u_host_io_port (.clk_sys, .reset_n, .host_select_n, .host_read_n, .host_write_low_byte_n,
    .host_write_high_byte_n, .host_addr, .host_data_in, .host_data_out, .host_data_oe, .transfer_ack_n_out,
    .transfer_ack_n_oe, .interrupt_ack_n, .priority_chain_in_n, .priority_out_or_disconnect, .irq_n_out,
    .irq_n_oe, .io_read_n, .io_write_n, .io_addr, .command_strobe, .discrete_data_in, .discrete_data_out,
    .discrete_data_oe, .rt_mode, .chain_select_disconnect, .store_disconnected, .mem_req_valid, .mem_req,
    .mem_ack, .mem_rdata, .fifo_not_empty, .fifo_vector, .fifo_pop, .io_req_valid, .io_req, .io_req_ready,
    .io_done, .io_rdata);
  far_side_model u_far_side_model (.clk_sys, .reset_n, .lat, .mem_req_valid, .mem_req, .mem_ack, .mem_rdata,
    .io_read_n, .io_addr, .discrete_data_out, .discrete_data_oe, .discrete_data_in);
  // host data pins: device, writing host or pull-up
  assign host_data_in = host_data_oe ? host_data_out
    : (host_write_low_byte_n && host_write_high_byte_n ? 16'hffff : hd);

  task automatic chk(input logic ok, input string msg);
    n_compared++;
    if (ok !== 1'b1) begin
      failures++;
      $display("mismatch at %0t: %s", $time, msg);
    end
  endtask : chk

  task automatic close_out;
    $display("compared %0d, failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : close_out

  task automatic host_cyc(input row_t r);
    int k;
    @(negedge clk_sys);
    lat = r.lat;
    host_addr = {10'h0, r.a};
    hd = r.d;
    host_select_n = 1'b0;
    host_read_n = r.wr;
    {host_write_high_byte_n, host_write_low_byte_n} = r.wr ? ~r.be : 2'h3;
    k = 0;
    do begin
      @(negedge clk_sys);
      k++;
    end while (transfer_ack_n_oe !== 1'b1 && k < 40);
    chk(k <= 37, "transfer ack late");
    chk(host_data_oe === !r.wr, "data drive wrong");
    q = host_data_out;
    host_select_n = 1'b1;
    host_read_n = 1'b1;
    {host_write_high_byte_n, host_write_low_byte_n} = 2'h3;
    repeat (4) @(negedge clk_sys);
    chk(transfer_ack_n_oe === 1'b0 && host_data_oe === 1'b0, "ack or data not released");
  endtask : host_cyc

  task automatic vec_read(input logic ok, output int w);
    @(negedge clk_sys);
    rt_mode = ok;
    // acknowledge leads the read strobe and outlasts it
    interrupt_ack_n = 1'b0;
    @(negedge clk_sys);
    host_read_n = 1'b0;
    w = 0;
    do begin
      @(negedge clk_sys);
      w++;
    end while (transfer_ack_n_oe !== 1'b1 && w < 20);
    chk(irq_n_oe === 1'b0, "request held during ack");
    q = host_data_out;
    host_read_n = 1'b1;
    @(negedge clk_sys);
    interrupt_ack_n = 1'b1;
    repeat (6) @(negedge clk_sys);
  endtask : vec_read

  initial begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end

  always @(posedge clk_sys) begin
    cyc++;
    if (fifo_pop === 1'b1) npop++;
    if (cyc == 3000) begin
      chk(1'b0, "timeout");
      close_out();
    end
  end

  initial begin
    reset_n = 1'b0;
    {host_select_n, host_read_n, host_write_low_byte_n, host_write_high_byte_n, interrupt_ack_n} = 5'h1f;
    {priority_chain_in_n, rt_mode, chain_select_disconnect, store_disconnected, fifo_not_empty} = 5'h10;
    io_req_valid = 1'b0;
    io_req = '0;
    host_addr = 14'h0;
    hd = 16'h0;
    fifo_vector = 8'h0;
    lat = 4'h0;
    repeat (6) @(posedge clk_sys);
    @(negedge clk_sys);
    reset_n = 1'b1;
    repeat (3) @(negedge clk_sys);
    chk({io_read_n, io_write_n, command_strobe, transfer_ack_n_oe, host_data_oe, io_req_ready, transfer_ack_n_out,
      irq_n_out, irq_n_oe} === 9'h188, "reset state");
    $display("reset done");
    foreach (rows[i]) begin
      host_cyc(rows[i]);
      if (!rows[i].wr) chk(q === rows[i].d, "read data");
      $display("memory row %0d done", i);
    end
    for (int k = 0; k < 4; k++) begin
      chk(io_req_ready === 1'b1, "sequencer not idle");
      io_req = '{k < 2, k[0], 2'(k), 8'(8'h3c + k)};
      io_req_valid = 1'b1;
      @(negedge clk_sys);
      io_req_valid = 1'b0;
      nlow = 0;
      // command strobe rises at the taking edge, before the first loop sample
      ncmd = command_strobe;
      n = 0;
      while (io_done !== 1'b1 && n < 30) begin
        @(negedge clk_sys);
        n++;
        nlow += (!io_read_n || !io_write_n);
        ncmd += command_strobe;
        // pin value, so a bus left undriven during the strobe reads as pull-up
        if (!io_write_n) wd = discrete_data_in;
      end
      chk(nlow == lw[k], "strobe width");
      chk(k[0] ? ncmd >= cw[k] : ncmd == 0, "command strobe length");
      chk(k < 2 ? wd === 8'(8'h3c + k) : io_rdata === {6'h28, 2'(k)}, "discrete data");
      $display("discrete kind %0d done", k);
    end
    fifo_vector = 8'h5a;
    fifo_not_empty = 1'b1;
    priority_chain_in_n = 1'b0;
    npop = 0;
    repeat (6) @(negedge clk_sys);
    chk(irq_n_oe === 1'b1 && priority_out_or_disconnect === 1'b1, "no request");
    vec_read(1'b1, n);
    chk(n >= 8 && n <= 10, "vector ack time");
    chk(q === 16'h5a5a && npop == 1, "vector or pop wrong");
    chk(irq_n_oe === 1'b1, "request not back");
    vec_read(1'b0, n);
    chk(n == 20 && npop == 1, "answered with rt mode off");
    fifo_not_empty = 1'b0;
    repeat (6) @(negedge clk_sys);
    chk(irq_n_oe === 1'b0, "request with fifo empty");
    $display("vector reads done");
    for (int v = 0; v < 4; v++) begin
      chain_select_disconnect = v[1];
      priority_chain_in_n = v[0];
      store_disconnected = !v[0];
      repeat (3) @(negedge clk_sys);
      chk(priority_out_or_disconnect === (v[1] ? !v[0] : v[0]), "chain output");
    end
    $display("chain done");
    close_out();
  end
endmodule : host_io_port_bench
`default_nettype wire
